// *** pm_pwm_defines.vh ***
`ifndef PM_PWM_DEFINES_VH
`define PM_PWM_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
// core clock rate in hertz (50 ns period)
`define CLK_HZ 20000000
// nominal output period in milliseconds
`define PERIOD_MS 1000
// fixed leading high and trailing low sections in microseconds
`define EDGE_US 200
// cycles per microsecond and per millisecond, derived from the rate
`define CYC_PER_US (`CLK_HZ / 1000000)
`define CYC_PER_MS (`CLK_HZ / 1000)
// leading / trailing section length in cycles (4000 at 20 MHz)
`define EDGE_CYCLES (`EDGE_US * `CYC_PER_US)
// full period in cycles (20,000,000 at 20 MHz)
`define PERIOD_CYCLES (`PERIOD_MS * `CYC_PER_MS)

// ----------------------------------------
// concentration scale
// ----------------------------------------
// full scale of the duty encoding, ug/m3
`define CONC_FULL 1000
`define CONC_FULL_11 11'h3e8

// ----------------------------------------
// mode command codes
// ----------------------------------------
`define CMD_STOP 8'h10
`define CMD_START 8'h11

`endif

// *** particle_duty_pwm_output.v ***
`timescale 1ns/1ps
`include "pm_pwm_defines.vh"

module particle_duty_pwm_output #(
  parameter PERIOD_CYCLES = `PERIOD_CYCLES,
  parameter EDGE_CYCLES = `EDGE_CYCLES,
  parameter CNT_W = 25
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RESETN,
  // power-on mode strap: high selects measurement, low standby
  input wire DEFAULT_MEASURE,
  // mode command from the serial front end
  input wire CMD_VALID,
  input wire [7:0] CMD_CODE,
  // fine-particle concentration, ug/m3
  input wire PM25_VALID,
  input wire [15:0] PM25_VALUE,
  // pulse-width pin and status
  output wire PWM_OUT,
  output wire MEASURING,
  output wire PERIOD_START
);

  // ----------------------------------------
  // constants at counter width
  // ----------------------------------------
  // integer forms first, then cut to the counter width on purpose
  localparam [31:0] PERIOD_LAST_W = PERIOD_CYCLES - 1;
  localparam [31:0] EDGE_LEN_W = EDGE_CYCLES;
  localparam [31:0] HIGH_MAX_W = PERIOD_CYCLES - EDGE_CYCLES;
  // cycles of high time per ug/m3 of concentration
  localparam [31:0] UNIT_CYCLES_W = PERIOD_CYCLES / `CONC_FULL;
  localparam [CNT_W-1:0] PERIOD_LAST = PERIOD_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] EDGE_LEN = EDGE_LEN_W[CNT_W-1:0];
  localparam [CNT_W-1:0] HIGH_MAX = HIGH_MAX_W[CNT_W-1:0];
  localparam [CNT_W-1:0] UNIT_CYCLES = UNIT_CYCLES_W[CNT_W-1:0];
  localparam PROD_W = CNT_W + 11;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  // strap not yet read after reset release
  localparam [1:0] MODE_POWERUP = 2'h0;
  // standby: pin held low, waiting for a start code
  localparam [1:0] MODE_IDLE = 2'h1;
  // measurement: periods run back to back
  localparam [1:0] MODE_RUN = 2'h2;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg stop_hit;
  reg start_hit;
  reg measuring_q;
  reg measuring_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg [CNT_W-1:0] high_len_q;
  reg [CNT_W-1:0] high_len_d;
  reg [10:0] conc_q;
  reg [10:0] conc_d;
  reg pwm_q;
  reg pwm_d;
  reg start_q;
  reg start_d;

  // ----------------------------------------
  // concentration to high time
  // ----------------------------------------
  reg [10:0] conc_sat;
  reg [PROD_W-1:0] prod;
  reg [CNT_W-1:0] high_calc;

  always @*
  begin
    conc_sat = conc_q;
    prod = {PROD_W{1'b0}};
    high_calc = EDGE_LEN;
    // saturate above full scale rather than wrap
    if (conc_sat > `CONC_FULL_11)
    begin
      conc_sat = `CONC_FULL_11;
    end
    // high time = conc * period / 1000
    prod = {{(PROD_W-11){1'b0}}, conc_sat} * {{(PROD_W-CNT_W){1'b0}}, UNIT_CYCLES};
    // keep the fixed start and end sections intact at both extremes;
    // a reading of 0 still gives a 200 us pulse, which decodes under 1 ug/m3
    if (prod < {{(PROD_W-CNT_W){1'b0}}, EDGE_LEN})
    begin
      high_calc = EDGE_LEN;
    end
    else if (prod > {{(PROD_W-CNT_W){1'b0}}, HIGH_MAX})
    begin
      high_calc = HIGH_MAX;
    end
    else
    begin
      high_calc = prod[CNT_W-1:0];
    end
  end

  // ----------------------------------------
  // mode, period counter and pin
  // ----------------------------------------
  always @*
  begin
    mode_d = mode_q;
    stop_hit = CMD_VALID && (CMD_CODE == `CMD_STOP);
    start_hit = CMD_VALID && (CMD_CODE == `CMD_START);
    measuring_d = measuring_q;
    cnt_d = cnt_q;
    high_len_d = high_len_q;
    conc_d = conc_q;
    start_d = 1'b0;

    // only the 2.5 micron figure is taken; coarse channels have no port
    if (PM25_VALID)
    begin
      conc_d = (PM25_VALUE > {5'h00, `CONC_FULL_11}) ? `CONC_FULL_11 : PM25_VALUE[10:0];
    end

    case (mode_q)
      MODE_POWERUP:
      begin
        // power-on mode caught on the first edge after reset release;
        // a command in that same cycle is overridden by the strap
        cnt_d = {CNT_W{1'b0}};
        high_len_d = high_calc;
        if (DEFAULT_MEASURE)
        begin
          mode_d = MODE_RUN;
          start_d = 1'b1;
        end
        else
        begin
          mode_d = MODE_IDLE;
        end
      end
      MODE_IDLE:
      begin
        // a stop code here changes nothing; codes other than start are ignored
        cnt_d = {CNT_W{1'b0}};
        if (start_hit)
        begin
          mode_d = MODE_RUN;
          high_len_d = high_calc;
          start_d = 1'b1;
        end
      end
      MODE_RUN:
      begin
        // a start code while running is ignored rather than restarting
        if (stop_hit)
        begin
          // abandon the current period at once; pin falls next edge
          mode_d = MODE_IDLE;
          cnt_d = {CNT_W{1'b0}};
        end
        else if (cnt_q == PERIOD_LAST)
        begin
          cnt_d = {CNT_W{1'b0}};
          // duty frozen per period so one rising-to-rising span is coherent
          high_len_d = high_calc;
          start_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default:
      begin
        // unused code: fall back to standby with the pin low
        mode_d = MODE_IDLE;
        cnt_d = {CNT_W{1'b0}};
      end
    endcase

    measuring_d = (mode_d == MODE_RUN);
    // high from period start for high_len cycles, then low to the end
    pwm_d = measuring_d && (cnt_d < high_len_d);
  end

  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mode_q <= MODE_POWERUP;
      measuring_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
      high_len_q <= {CNT_W{1'b0}};
      conc_q <= 11'h000;
      pwm_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      measuring_q <= measuring_d;
      cnt_q <= cnt_d;
      high_len_q <= high_len_d;
      conc_q <= conc_d;
      pwm_q <= pwm_d;
      start_q <= start_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PWM_OUT = pwm_q;
  assign MEASURING = measuring_q;
  assign PERIOD_START = start_q;

endmodule

// *** particle_duty_pwm_output_chk.sv ***
`timescale 1ns/1ps
module pwm_chk #(
  parameter PERIOD_CYCLES = 2000
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic PWM_OUT,
  input wire logic MEASURING,
  input wire logic PERIOD_START
);
  // ----------------
  // period counter
  // ----------------
  logic [15:0] cnt_q;
  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      cnt_q <= 16'h0;
    else
      cnt_q <= PERIOD_START ? 16'h0 : cnt_q + 16'h1;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  start_high_a: assert property (PERIOD_START |-> PWM_OUT) else $error("low at start");
  rise_marked_a: assert property ($rose(PWM_OUT) |-> PERIOD_START) else $error("bad rise");
  lead_high_a: assert property (PERIOD_START |=> PWM_OUT [*8]) else $error("short high");
  trail_low_a: assert property ($fell(PWM_OUT) && MEASURING |-> !PWM_OUT [*8])
    else $error("short low");
  period_len_a: assert property (PERIOD_START && $past(MEASURING) |->
    cnt_q == 16'(PERIOD_CYCLES - 1)) else $error("period length");
  standby_quiet_a: assert property (!MEASURING |-> !PWM_OUT) else $error("pin active");
  stop_cmd_a: assert property (CMD_VALID && CMD_CODE == 8'h10 |=> !MEASURING && !PWM_OUT)
    else $error("stop ignored");
  start_cmd_a: assert property (CMD_VALID && CMD_CODE == 8'h11 && !MEASURING |=>
    MEASURING && PERIOD_START) else $error("start ignored");
endmodule

// *** host_capture.sv ***
`timescale 1ns/1ps
// counts whole periods rising edge to rising edge; the span before the first rising edge (arming) is dropped
module host_capture (
  input wire logic clk,
  input wire logic pwm,
  output logic [15:0] high_time,
  output logic [15:0] low_time,
  output logic done
);
  logic pwm_q = 1'b0;
  logic armed_q = 1'b0;
  logic [15:0] hc_q = 16'h0;
  logic [15:0] lc_q = 16'h0;
  always @(posedge clk)
  begin
    pwm_q <= pwm;
    done <= 1'b0;
    if (pwm && !pwm_q)
    begin
      high_time <= hc_q;
      low_time <= lc_q;
      done <= armed_q;
      armed_q <= 1'b1;
      hc_q <= 16'h1;
      lc_q <= 16'h0;
    end
    else if (pwm)
      hc_q <= hc_q + 16'h1;
    else
      lc_q <= lc_q + 16'h1;
  end
endmodule

// *** tb_particle_duty_pwm_output.sv ***
`timescale 1ns/1ps
`define CHK(a, b) checked++; if ((a) !== (b)) begin failures++; \
  $display("mismatch %0t %h %h", $time, a, b); end
module tb_particle_duty_pwm_output;
  localparam P = 2000;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic DEFAULT_MEASURE = 1'b0;
  logic CMD_VALID = 1'b0;
  logic [7:0] CMD_CODE = 8'h0;
  logic PM25_VALID = 1'b0;
  logic [15:0] PM25_VALUE = 16'h0;
  logic PWM_OUT, MEASURING, PERIOD_START, done;
  logic [15:0] high_time, low_time;
  int failures = 0;
  int checked = 0;
  always #25 CORE_CLK = ~CORE_CLK;
  particle_duty_pwm_output #(.PERIOD_CYCLES(P), .EDGE_CYCLES(20)) dut (.CORE_CLK(CORE_CLK),
    .RESETN(RESETN), .DEFAULT_MEASURE(DEFAULT_MEASURE), .CMD_VALID(CMD_VALID),
    .CMD_CODE(CMD_CODE), .PM25_VALID(PM25_VALID), .PM25_VALUE(PM25_VALUE),
    .PWM_OUT(PWM_OUT), .MEASURING(MEASURING), .PERIOD_START(PERIOD_START));
  host_capture host (.clk(CORE_CLK), .pwm(PWM_OUT), .high_time(high_time), .low_time(low_time),
    .done(done));
  task step(int n);
    repeat (n) @(posedge CORE_CLK);
    #2;
  endtask
  task summarize;
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cmd(logic [7:0] code);
    CMD_VALID = 1'b1;
    CMD_CODE = code;
    step(1);
    CMD_VALID = 1'b0;
  endtask
  task wait_done;
    int i;
    for (i = 0; i < 3 * P && done !== 1'b1; i++)
      step(1);
    if (done !== 1'b1)
    begin
      failures++;
      summarize;
    end
    step(1);
  endtask
  task duty(logic [15:0] v, logic [15:0] exp);
    PM25_VALID = 1'b1;
    PM25_VALUE = v;
    step(1);
    PM25_VALID = 1'b0;
    wait_done;
    wait_done;
    `CHK(high_time, exp)
    `CHK(high_time + low_time, 16'(P))
  endtask
  task test_standby_default;
    step(100);
    `CHK({MEASURING, PWM_OUT}, 2'b00)
    cmd(8'h10);
    `CHK({MEASURING, PWM_OUT}, 2'b00)
  endtask
  task test_commands;
    cmd(8'h12);
    `CHK(MEASURING, 1'b0)
    cmd(8'h11);
    `CHK({MEASURING, PERIOD_START, PWM_OUT}, 3'b111)
    step(1);
    cmd(8'h11);
    `CHK({MEASURING, PERIOD_START}, 2'b10)
  endtask
  task test_duty_scale;
    duty(16'h0000, 16'h0014);
    duty(16'h00fa, 16'h01f4);
    duty(16'h03e8, 16'h07bc);
    duty(16'h05dc, 16'h07bc);
  endtask
  task test_stop_restart;
    cmd(8'h10);
    `CHK({MEASURING, PWM_OUT}, 2'b00)
    step(10);
    `CHK({MEASURING, PWM_OUT}, 2'b00)
    cmd(8'h11);
    `CHK({MEASURING, PERIOD_START, PWM_OUT}, 3'b111)
    wait_done;
    wait_done;
    `CHK(low_time, 16'h0014)
    `CHK(high_time + low_time, 16'(P))
  endtask
  task test_strap_measure;
    DEFAULT_MEASURE = 1'b1;
    RESETN = 1'b0;
    step(16);
    RESETN = 1'b1;
    step(1);
    `CHK({MEASURING, PWM_OUT, PERIOD_START}, 3'b111)
  endtask
  initial
  begin
    step(16);
    RESETN = 1'b1;
    test_standby_default;
    test_commands;
    test_duty_scale;
    test_stop_restart;
    test_strap_measure;
    summarize;
  end
endmodule
bind particle_duty_pwm_output pwm_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) chk (.CORE_CLK(CORE_CLK),
  .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .PWM_OUT(PWM_OUT),
  .MEASURING(MEASURING), .PERIOD_START(PERIOD_START));
